// ---- rtl/bfp_pkg.sv ----
// Purpose: shared constants and types of the breaker failure supervision block
// Assumes: one 250 MHz system clock, settings in whole ms and whole percent
// Notes:   settings not printed as defaults carry plain values of our own
// ****************************************************************************
// package
// ****************************************************************************
package bfp_pkg;
  // clock and millisecond timebase
  localparam int unsigned CLK_PERIOD_NS   = 4;                        // 250 MHz
  localparam int unsigned MS_NS           = 1_000_000;                // one ms in ns
  localparam int unsigned TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;    // cycles per ms
  localparam int          TICK_W          = 18;                       // holds 250000
  // widths
  localparam int NPH    = 3;                                          // phases
  localparam int MS_W   = 16;                                         // ms settings
  localparam int PCT_W  = 8;                                          // percent levels
  localparam int CUR_W  = 16;                                         // measured percent
  localparam int TRIP_N = 8;                                          // selectable trips
  localparam int SEL_W  = 3;                                          // trip selector
  // setting reset values
  localparam logic [MS_W-1:0]  BACKUP_DELAY_DEF = 16'h00c8;           // 200 ms
  localparam logic [MS_W-1:0]  RETRIP_DELAY_DEF = 16'h0064;           // plain default
  localparam logic [MS_W-1:0]  PULSE_LEN_DEF    = 16'h0064;           // 100 ms
  localparam logic [PCT_W-1:0] PHASE_LVL_DEF    = 8'h1e;              // 30 %
  localparam logic [PCT_W-1:0] RESID_LVL_DEF    = 8'h1e;              // 30 %
  localparam logic [SEL_W-1:0] START_SEL_DEF    = 3'h0;               // first trip
  localparam logic [MS_W-1:0]  MS_ONE           = 16'h0001;           // one ms step
  localparam logic [MS_W-1:0]  MS_ZERO          = 16'h0000;           // cleared timer

  // operating mode of the supervision
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CURRENT,
    MODE_CONTACT,
    MODE_BOTH
  } bfp_mode_t;

  // per-phase supervision state
  typedef enum logic {
    PH_IDLE,
    PH_RUN
  } bfp_ph_t;

  // fault still present for the chosen mode; unused inputs are ignored
  function automatic logic bfp_fault(input bfp_mode_t m, input logic cur_hi, input logic closed);
    case (m)
      MODE_CURRENT: bfp_fault = cur_hi;
      MODE_CONTACT: bfp_fault = closed;
      MODE_BOTH:    bfp_fault = cur_hi | closed;
      default:      bfp_fault = 1'b0;
    endcase
  endfunction
endpackage

// ---- rtl/bfp_ms_tick.sv ----
// Purpose: one-cycle enable pulse once per millisecond
// Assumes: TICK_CYCLES of at least ten
// Notes:   shorten TICK_CYCLES in simulation
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// millisecond prescaler
// ****************************************************************************
module bfp_ms_tick #(
  parameter int unsigned TICK_CYCLES = bfp_pkg::TICK_CYCLES_DEF
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  output var  logic tick_q
);
  import bfp_pkg::*;

  logic [TICK_W-1:0] cnt_q;   // cycles into the current ms
  logic [TICK_W-1:0] cnt_d;
  logic              tick_d;

  // [R15] ms prescaler
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + TICK_W'(1);
    if (cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  // ticks never come closer than the window below
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tick_q |=> !tick_q [*8]) else $error("ms ticks too close"); // [R15]
endmodule
`default_nettype wire

// ---- rtl/bfp_core.sv ----
// Purpose: breaker failure supervision with backup and repeat trip pulses
// Assumes: inputs synchronous to clk_sys; currents in percent of nominal
// Notes:   settings are taken on cfg_load and held; timers run on ms ticks
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// breaker failure core
// ****************************************************************************
// How it works
// [R1] start edge launches backup and retrip timers
// [R2] start picked from selectable trip inputs
// [R3] supervise current, contacts or both
// [R4] current mode ignores pole contacts
// [R5] contact mode ignores current levels
// [R6] idle only when all faults cleared
// [R7] backup trip only on expired faulty phase
// [R8] backup delay in ms, default 200
// [R9] repeat trip after own delay when enabled
// [R10] trip pulses last pulse length ms
// [R11] modes off, current, contact, both
// [R12] phase pickup percent, default 30
// [R13] residual pickup percent, default 30
// [R14] blocking input inhibits operation dynamically
// [R15] ms tick from system clock prescaler
// [R16] block clears timers and trip outputs
module bfp_core #(
  parameter int unsigned TICK_CYCLES = bfp_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic [bfp_pkg::TRIP_N-1:0] trip_in,
  input  wire logic                     block_in,
  input  wire logic [bfp_pkg::CUR_W-1:0]  phase_cur_l1,
  input  wire logic [bfp_pkg::CUR_W-1:0]  phase_cur_l2,
  input  wire logic [bfp_pkg::CUR_W-1:0]  phase_cur_l3,
  input  wire logic [bfp_pkg::CUR_W-1:0]  resid_cur,
  input  wire logic [bfp_pkg::NPH-1:0]    pole_closed,
  input  wire logic                     cfg_load,
  input  wire bfp_pkg::bfp_mode_t       cfg_mode,
  input  wire logic                     cfg_retrip_en,
  input  wire logic [bfp_pkg::SEL_W-1:0]  cfg_start_sel,
  input  wire logic [bfp_pkg::PCT_W-1:0]  cfg_phase_pickup_level,
  input  wire logic [bfp_pkg::PCT_W-1:0]  cfg_resid_pickup_level,
  input  wire logic [bfp_pkg::MS_W-1:0]   cfg_backup_delay,
  input  wire logic [bfp_pkg::MS_W-1:0]   cfg_retrip_delay,
  input  wire logic [bfp_pkg::MS_W-1:0]   cfg_pulse_len,
  output var  logic [bfp_pkg::NPH-1:0]    backup_trip_q,
  output var  logic [bfp_pkg::NPH-1:0]    repeat_trip_q,
  output var  logic [bfp_pkg::NPH-1:0]    phase_busy_q
);
  import bfp_pkg::*;

  // ****************************************************************************
  // settings
  // ****************************************************************************
  bfp_mode_t        mode_q, mode_d;             // operating mode
  logic             rt_en_q, rt_en_d;           // repeat trip enable
  logic [SEL_W-1:0] sel_q, sel_d;               // start source
  logic [PCT_W-1:0] ph_lvl_q, ph_lvl_d;         // phase pickup level
  logic [PCT_W-1:0] res_lvl_q, res_lvl_d;       // residual pickup level
  logic [MS_W-1:0]  bk_dly_q, bk_dly_d;         // backup delay
  logic [MS_W-1:0]  rt_dly_q, rt_dly_d;         // repeat delay
  logic [MS_W-1:0]  pl_q, pl_d;                 // pulse length

  // settings change as one set so a half-written setup never acts
  always_comb begin
    mode_d    = mode_q;
    rt_en_d   = rt_en_q;
    sel_d     = sel_q;
    ph_lvl_d  = ph_lvl_q;
    res_lvl_d = res_lvl_q;
    bk_dly_d  = bk_dly_q;
    rt_dly_d  = rt_dly_q;
    pl_d      = pl_q;
    if (cfg_load) begin
      mode_d    = cfg_mode;
      rt_en_d   = cfg_retrip_en;
      sel_d     = cfg_start_sel;
      ph_lvl_d  = cfg_phase_pickup_level;
      res_lvl_d = cfg_resid_pickup_level;
      bk_dly_d  = cfg_backup_delay;
      rt_dly_d  = cfg_retrip_delay;
      pl_d      = cfg_pulse_len;
    end
  end

  // [R8] [R11] [R12] [R13] documented defaults
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q    <= MODE_CURRENT;
      rt_en_q   <= 1'b0;
      sel_q     <= START_SEL_DEF;
      ph_lvl_q  <= PHASE_LVL_DEF;
      res_lvl_q <= RESID_LVL_DEF;
      bk_dly_q  <= BACKUP_DELAY_DEF;
      rt_dly_q  <= RETRIP_DELAY_DEF;
      pl_q      <= PULSE_LEN_DEF;
    end else begin
      mode_q    <= mode_d;
      rt_en_q   <= rt_en_d;
      sel_q     <= sel_d;
      ph_lvl_q  <= ph_lvl_d;
      res_lvl_q <= res_lvl_d;
      bk_dly_q  <= bk_dly_d;
      rt_dly_q  <= rt_dly_d;
      pl_q      <= pl_d;
    end
  end

  // ****************************************************************************
  // timebase and start edge
  // ****************************************************************************
  logic             tick;                       // one ms enable
  logic             start_now;                  // selected trip level
  logic             start_prev_q, start_prev_d; // last sampled level
  logic             start_rise;                 // launch event
  logic             run_ok;                     // enabled and not blocked
  logic [CUR_W-1:0] ph_cur [NPH];               // phase currents as array
  logic [NPH-1:0]   flt;                        // fault still present

  bfp_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick_q  (tick)
  );

  assign ph_cur[0] = phase_cur_l1;
  assign ph_cur[1] = phase_cur_l2;
  assign ph_cur[2] = phase_cur_l3;

  // [R2] selectable start source
  assign start_now    = trip_in[sel_q];
  assign start_prev_d = start_now;
  assign start_rise   = start_now & ~start_prev_q;
  // [R11] [R14] off or blocked stops all
  assign run_ok = (mode_q != MODE_OFF) && !block_in;

  // [R3] [R4] [R5] fault per phase by mode
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      flt[i] = bfp_fault(mode_q,
                         (ph_cur[i] >= CUR_W'(ph_lvl_q)) || (resid_cur >= CUR_W'(res_lvl_q)),
                         pole_closed[i]);
    end
  end

  // ****************************************************************************
  // per-phase timers and pulses
  // ****************************************************************************
  bfp_ph_t         st_q [NPH], st_d [NPH];     // supervision state
  logic [MS_W-1:0] bk_cnt_q [NPH], bk_cnt_d [NPH]; // backup ms elapsed
  logic [MS_W-1:0] rt_cnt_q [NPH], rt_cnt_d [NPH]; // repeat ms elapsed
  logic [MS_W-1:0] bk_pl_q [NPH], bk_pl_d [NPH];   // backup pulse ms left
  logic [MS_W-1:0] rt_pl_q [NPH], rt_pl_d [NPH];   // repeat pulse ms left
  logic [NPH-1:0]  bk_done_q, bk_done_d;       // backup already fired
  logic [NPH-1:0]  rt_done_q, rt_done_d;       // repeat already fired
  logic [NPH-1:0]  bk_trip_d, rt_trip_d, busy_d;

  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      st_d[i]      = st_q[i];
      bk_cnt_d[i]  = bk_cnt_q[i];
      rt_cnt_d[i]  = rt_cnt_q[i];
      bk_pl_d[i]   = bk_pl_q[i];
      rt_pl_d[i]   = rt_pl_q[i];
      bk_done_d[i] = bk_done_q[i];
      rt_done_d[i] = rt_done_q[i];
      bk_trip_d[i] = backup_trip_q[i];
      rt_trip_d[i] = repeat_trip_q[i];
      // [R10] running pulses shorten one ms per tick
      if (tick && backup_trip_q[i]) begin
        bk_pl_d[i] = bk_pl_q[i] - MS_ONE;
        if (bk_pl_q[i] == MS_ONE) bk_trip_d[i] = 1'b0;
      end
      if (tick && repeat_trip_q[i]) begin
        rt_pl_d[i] = rt_pl_q[i] - MS_ONE;
        if (rt_pl_q[i] == MS_ONE) rt_trip_d[i] = 1'b0;
      end
      case (st_q[i])
        PH_IDLE: begin
          // [R1] launch both timers
          if (start_rise) begin
            st_d[i]      = PH_RUN;
            bk_cnt_d[i]  = MS_ZERO;
            rt_cnt_d[i]  = MS_ZERO;
            bk_done_d[i] = 1'b0;
            rt_done_d[i] = 1'b0;
          end
        end
        PH_RUN: begin
          if (start_rise) begin
            // a fresh start restarts the timers of this phase
            bk_cnt_d[i]  = MS_ZERO;
            rt_cnt_d[i]  = MS_ZERO;
            bk_done_d[i] = 1'b0;
            rt_done_d[i] = 1'b0;
          end else if (!flt[i]) begin
            // [R6] fault gone for the mode, back to idle
            st_d[i] = PH_IDLE;
          end else if (tick) begin
            // [R7] [R8] backup expiry on a faulty phase
            if (!bk_done_q[i]) begin
              bk_cnt_d[i] = bk_cnt_q[i] + MS_ONE;
              if (bk_cnt_d[i] >= bk_dly_q) begin
                bk_done_d[i] = 1'b1;
                bk_trip_d[i] = (pl_q != MS_ZERO);
                bk_pl_d[i]   = pl_q;
              end
            end
            // [R9] repeat trip only when enabled
            if (!rt_done_q[i] && rt_en_q) begin
              rt_cnt_d[i] = rt_cnt_q[i] + MS_ONE;
              if (rt_cnt_d[i] >= rt_dly_q) begin
                rt_done_d[i] = 1'b1;
                rt_trip_d[i] = (pl_q != MS_ZERO);
                rt_pl_d[i]   = pl_q;
              end
            end
          end
        end
        default: st_d[i] = PH_IDLE;
      endcase
      // [R14] [R16] block or off clears everything
      if (!run_ok) begin
        st_d[i]      = PH_IDLE;
        bk_cnt_d[i]  = MS_ZERO;
        rt_cnt_d[i]  = MS_ZERO;
        bk_pl_d[i]   = MS_ZERO;
        rt_pl_d[i]   = MS_ZERO;
        bk_done_d[i] = 1'b0;
        rt_done_d[i] = 1'b0;
        bk_trip_d[i] = 1'b0;
        rt_trip_d[i] = 1'b0;
      end
      busy_d[i] = (st_d[i] == PH_RUN);
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_prev_q  <= 1'b0;
      bk_done_q     <= '0;
      rt_done_q     <= '0;
      backup_trip_q <= '0;
      repeat_trip_q <= '0;
      phase_busy_q  <= '0;
      for (int i = 0; i < NPH; i++) begin
        st_q[i]     <= PH_IDLE;
        bk_cnt_q[i] <= MS_ZERO;
        rt_cnt_q[i] <= MS_ZERO;
        bk_pl_q[i]  <= MS_ZERO;
        rt_pl_q[i]  <= MS_ZERO;
      end
    end else begin
      start_prev_q  <= start_prev_d;
      bk_done_q     <= bk_done_d;
      rt_done_q     <= rt_done_d;
      backup_trip_q <= bk_trip_d;
      repeat_trip_q <= rt_trip_d;
      phase_busy_q  <= busy_d;
      for (int i = 0; i < NPH; i++) begin
        st_q[i]     <= st_d[i];
        bk_cnt_q[i] <= bk_cnt_d[i];
        rt_cnt_q[i] <= rt_cnt_d[i];
        bk_pl_q[i]  <= bk_pl_d[i];
        rt_pl_q[i]  <= rt_pl_d[i];
      end
    end
  end

  // ****************************************************************************
  // checks
  // ****************************************************************************
  logic [MS_W-1:0] hp_ticks_q;  // ticks seen while phase one backup pulse is high

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) hp_ticks_q <= MS_ZERO;
    else if (!backup_trip_q[0]) hp_ticks_q <= MS_ZERO;
    else if (tick) hp_ticks_q <= hp_ticks_q + MS_ONE;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_start_launch: assert property (start_rise && run_ok |=> &phase_busy_q) // [R1]
    else $error("start edge did not launch timers");
  a_start_source: assert property (trip_in[sel_q] && !$past(trip_in[sel_q]) && run_ok && !cfg_load
    |=> &phase_busy_q) // [R2]
    else $error("selected trip did not start");
  a_cur_no_contact: assert property (mode_q == MODE_CURRENT && !block_in && phase_busy_q[0] && !start_rise
    && phase_cur_l1 < CUR_W'(ph_lvl_q) && resid_cur < CUR_W'(res_lvl_q) |=> !phase_busy_q[0]) // [R4]
    else $error("contacts held current mode");
  a_con_no_current: assert property (mode_q == MODE_CONTACT && !block_in && phase_busy_q[0] && !start_rise
    && !pole_closed[0] |=> !phase_busy_q[0]) // [R5]
    else $error("current held contact mode");
  a_idle_when_clear: assert property (!flt[1] && !start_rise |=> !phase_busy_q[1]) // [R6]
    else $error("phase stayed busy without fault");
  a_backup_only_busy: assert property ($rose(backup_trip_q[2]) |-> $past(phase_busy_q[2]) && $past(flt[2])
    && $past(bk_cnt_q[2]) + MS_ONE >= $past(bk_dly_q)) // [R7] [R8]
    else $error("backup trip without expired fault");
  a_retrip_enabled: assert property ($rose(repeat_trip_q[0]) |-> $past(rt_en_q) && $past(tick)) // [R9]
    else $error("repeat trip while disabled");
  a_pulse_width: assert property ($fell(backup_trip_q[0]) && $past(run_ok)
    |-> $past(hp_ticks_q) + MS_ONE == $past(pl_q)) // [R10]
    else $error("backup pulse length wrong");
  a_off_quiet: assert property (mode_q == MODE_OFF |=> phase_busy_q == '0 && backup_trip_q == '0) // [R11]
    else $error("off mode still active");
  a_block_clears: assert property (block_in |=> phase_busy_q == '0 && backup_trip_q == '0
    && repeat_trip_q == '0) // [R14] [R16]
    else $error("block did not clear outputs");

  c_backup_fire: cover property ($rose(backup_trip_q[0]));
  c_retrip_fire: cover property ($rose(repeat_trip_q[1]));
  c_block_busy:  cover property (phase_busy_q[2] && block_in);
  c_clear_idle:  cover property ($fell(phase_busy_q[0]) && !$past(block_in));
endmodule
`default_nettype wire

// ---- tb/bfp_grid_model.sv ----
// Purpose: far side model: trip source, current sensing and breaker poles
// Assumes: breaker opens OPEN_CYC + 1 cycles after the protection trip
// Notes:   stuck masks model welded contacts or arcing current
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// grid and breaker model
// ****************************************************************************
module bfp_grid_model #(
  parameter int OPEN_CYC = 15
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        prot_trip,
  input  wire logic [2:0]  trip_idx,
  input  wire logic        fault_on,
  input  wire logic [2:0]  pole_stuck,
  input  wire logic [2:0]  cur_stuck,
  input  wire logic [15:0] cur_level,
  input  wire logic [15:0] resid_level,
  output logic      [7:0]  trip_in,
  output logic      [15:0] phase_cur_l1,
  output logic      [15:0] phase_cur_l2,
  output logic      [15:0] phase_cur_l3,
  output logic      [15:0] resid_cur,
  output logic      [2:0]  pole_closed
);
  int   cnt_q;   // cycles since the trip reached the breaker
  logic open_q;  // breaker mechanism has moved
  logic [2:0] flow;

  assign trip_in = 8'(8'h01 << trip_idx) & {8{prot_trip}};

  // breaker moves a fixed time after trip; recloses once fault is gone
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 0;
      open_q <= 1'b0;
    end else if (!fault_on) begin
      cnt_q  <= 0;
      open_q <= 1'b0;
    end else if (prot_trip && cnt_q < OPEN_CYC) begin
      cnt_q <= cnt_q + 1;
    end else if (cnt_q == OPEN_CYC) begin
      open_q <= 1'b1;
    end
  end

  // a stuck pole still reads closed, an arcing pole still carries current
  assign flow         = {3{fault_on}} & ({3{!open_q}} | cur_stuck);
  assign phase_cur_l1 = flow[0] ? cur_level : 16'h0000;
  assign phase_cur_l2 = flow[1] ? cur_level : 16'h0000;
  assign phase_cur_l3 = flow[2] ? cur_level : 16'h0000;
  assign resid_cur    = fault_on ? resid_level : 16'h0000;
  assign pole_closed  = {3{!open_q}} | pole_stuck;
endmodule
`default_nettype wire

// ---- tb/bfp_core_test.sv ----
// Purpose: self-checking bench of the breaker failure core
// Assumes: ten clocks per ms tick, short delays loaded by cfg_load
// Notes:   inputs move on the falling edge, outputs sampled there too
`timescale 1ns/10ps
`default_nettype none
module bfp_core_test;
  import bfp_pkg::*;
  localparam int TICKS = 10;  // short tick keeps the default run brief
  logic clk_sys, arst_n, block_in, cfg_load, cfg_retrip_en, prot_trip, fault_on;
  bfp_mode_t         cfg_mode;
  logic [SEL_W-1:0]  cfg_start_sel, trip_idx;
  logic [CUR_W-1:0]  cur_level, resid_level, cur1, cur2, cur3, resid_cur;
  logic [NPH-1:0]    pole_stuck, cur_stuck, pole_closed, bk_q, rp_q, busy_q;
  logic [TRIP_N-1:0] trip_in;
  int                n_fail, n_compared;
  logic [PCT_W-1:0]  ph_lvl;   // phase pickup level taken on cfg_load

  bfp_core #(.TICK_CYCLES(TICKS)) u_bfp_core (
    .clk_sys(clk_sys), .arst_n(arst_n), .trip_in(trip_in), .block_in(block_in),
    .phase_cur_l1(cur1), .phase_cur_l2(cur2), .phase_cur_l3(cur3), .resid_cur(resid_cur),
    .pole_closed(pole_closed), .cfg_load(cfg_load), .cfg_mode(cfg_mode),
    .cfg_retrip_en(cfg_retrip_en), .cfg_start_sel(cfg_start_sel),
    .cfg_phase_pickup_level(ph_lvl), .cfg_resid_pickup_level(8'h1e),
    // repeat delay of 3 ms always lands after the model's breaker has opened,
    // so a pole that opened and stopped carrying current never sees a repeat trip whatever the tick phase
    .cfg_backup_delay(16'h0004), .cfg_retrip_delay(16'h0003), .cfg_pulse_len(16'h0002),
    .backup_trip_q(bk_q), .repeat_trip_q(rp_q), .phase_busy_q(busy_q));

  bfp_grid_model u_bfp_grid_model (
    .clk_sys(clk_sys), .arst_n(arst_n), .prot_trip(prot_trip), .trip_idx(trip_idx),
    .fault_on(fault_on), .pole_stuck(pole_stuck), .cur_stuck(cur_stuck),
    .cur_level(cur_level), .resid_level(resid_level), .trip_in(trip_in),
    .phase_cur_l1(cur1), .phase_cur_l2(cur2), .phase_cur_l3(cur3),
    .resid_cur(resid_cur), .pole_closed(pole_closed));

  // compare one value, count it, report a mismatch at once
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // load mode, repeat enable and start selector in one cycle
  task automatic cfg(input bfp_mode_t m, input logic rt, input logic [2:0] sel);
    @(negedge clk_sys);
    cfg_mode      = m;
    cfg_retrip_en = rt;
    cfg_start_sel = sel;
    cfg_load      = 1'b1;
    @(negedge clk_sys);
    cfg_load = 1'b0;
  endtask

  // one fault episode: gather trips seen, busy sampled after the breaker moved
  task automatic run(input logic [2:0] ps, input logic [2:0] cs, output logic [2:0] bk,
                     output logic [2:0] rp, output logic [2:0] busy);
    bk = 3'h0;
    rp = 3'h0;
    busy = 3'h0;
    @(negedge clk_sys);
    pole_stuck = ps;
    cur_stuck  = cs;
    fault_on   = 1'b1;
    @(negedge clk_sys);
    prot_trip = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk_sys);
      bk = bk | bk_q;
      rp = rp | rp_q;
      if (i == 25) busy = busy_q;
    end
    prot_trip   = 1'b0;
    fault_on    = 1'b0;
    resid_level = 16'h0000;
    repeat (30) @(negedge clk_sys);
  endtask

  // default settings: 200 ms backup, 100 ms pulse, level exactly 30 %
  task automatic t_default();
    int k;
    int w;
    k = 0;
    w = 0;
    cur_level = 16'h001e;
    @(negedge clk_sys);
    pole_stuck = 3'h1;
    cur_stuck  = 3'h1;
    fault_on   = 1'b1;
    @(negedge clk_sys);
    prot_trip = 1'b1;
    while (bk_q[0] !== 1'b1 && k < 2100) begin
      @(negedge clk_sys);
      k++;
    end
    check(16'(k >= 199 * TICKS && k <= 200 * TICKS + 2), 16'h1, "backup delay");
    check(16'(bk_q), 16'h1, "only stuck phase");
    while (bk_q[0] === 1'b1 && w < 1100) begin
      @(negedge clk_sys);
      w++;
      if (rp_q !== 3'h0) k = -1;
    end
    check(16'(w), 16'(100 * TICKS), "pulse width");
    check(16'(k >= 0), 16'h1, "no repeat trip");
    prot_trip = 1'b0;
    fault_on  = 1'b0;
    repeat (30) @(negedge clk_sys);
    $display("test default done");
  endtask

  // current mode: poles ignored, below-level current clears
  task automatic t_current();
    logic [2:0] bk, rp, b;
    cfg(MODE_CURRENT, 1'b0, 3'h0);
    run(3'h7, 3'h2, bk, rp, b);
    check(16'(b), 16'h2, "busy current");
    check(16'(bk), 16'h2, "backup current");
    check(16'(rp), 16'h0, "repeat off");
    cur_level = 16'h001d;
    run(3'h0, 3'h7, bk, rp, b);
    check(16'({b, bk}), 16'h0, "below level");
    // a lower programmed pickup makes the same current a fault
    ph_lvl = 8'h1c;
    cfg(MODE_CURRENT, 1'b0, 3'h0);
    run(3'h0, 3'h7, bk, rp, b);
    check(16'(bk), 16'h7, "lower pickup");
    ph_lvl = 8'h1e;
    cur_level = 16'h001e;
    resid_level = 16'h001e;
    run(3'h0, 3'h0, bk, rp, b);
    check(16'(bk), 16'h7, "residual holds");
    $display("test current done");
  endtask

  // contact mode ignores current; both mode and repeat trip
  task automatic t_contact_both();
    logic [2:0] bk, rp, b;
    cfg(MODE_CONTACT, 1'b0, 3'h0);
    run(3'h4, 3'h3, bk, rp, b);
    check(16'({b, bk}), 16'h24, "contact mode");
    cfg(MODE_BOTH, 1'b1, 3'h0);
    run(3'h1, 3'h2, bk, rp, b);
    check(16'({bk, rp}), 16'h1b, "both mode trips");
    $display("test contact both done");
  endtask

  // off mode, blocking in mid run, start selector
  task automatic t_inhibit();
    logic [2:0] bk, rp, b;
    cfg(MODE_OFF, 1'b1, 3'h0);
    run(3'h7, 3'h7, bk, rp, b);
    check(16'({b, bk, rp}), 16'h0, "off mode");
    cfg(MODE_CURRENT, 1'b1, 3'h5);
    run(3'h7, 3'h7, bk, rp, b);
    check(16'(b), 16'h0, "other trip ignored");
    trip_idx = 3'h5;
    fork
      run(3'h7, 3'h7, bk, rp, b);
      begin
        repeat (12) @(negedge clk_sys);
        check(16'(busy_q), 16'h7, "selected start");
        // user condition blocks in mid run
        block_in = 1'b1;
      end
    join
    check(16'({b, bk, rp}), 16'h0, "blocked");
    block_in = 1'b0;
    trip_idx = 3'h0;
    $display("test inhibit done");
  endtask

  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // watchdog well past the expected run of about 4000 cycles
  initial begin
    #100us;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    {n_fail, n_compared} = '0;
    {arst_n, block_in, cfg_load, cfg_retrip_en, prot_trip, fault_on} = '0;
    cfg_mode = MODE_CURRENT;
    {cfg_start_sel, trip_idx, pole_stuck, cur_stuck} = '0;
    {cur_level, resid_level} = '0;
    ph_lvl = 8'h1e;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    check(16'({bk_q, rp_q, busy_q}), 16'h0, "reset outputs");
    t_default();
    t_current();
    t_contact_both();
    t_inhibit();
    final_report();
  end
endmodule
`default_nettype wire
